// [design/cog_delay_buffer.sv]
/*
 * Complementary output generator timing stages with double-buffered counts.
 * Holds the APB register file, the working count buffers and the
 * blanking, phase and dead-band stages feeding the two output flops.
 * Assumes rising/falling event inputs are synchronous on-chip levels.
 */
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module cog_delay_buffer import cog_pkg::*; (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RISE_EVENT,
    input wire logic FALL_EVENT,
    output logic OUT0,
    output logic OUT1
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic load_pending;
        count_set_t shadow;
        count_set_t work;
        apb_rsp_t rsp;
        logic drive;
        logic out0;
        logic out1;
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;

    apb_req_t req;
    logic blank_rise_q;
    logic blank_fall_q;
    logic phase_rise_q;
    logic phase_fall_q;
    logic dead_rise_q;
    logic dead_fall_q;
    logic out_level;

    assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR,
                   pwdata: PWDATA};

    // ------------------------------------------------------------------
    // Timing stages
    // ------------------------------------------------------------------
    // Blanking sits first so masked edges never reach the phase counter
    cog_delay_stage #(.WIDTH(COUNT_WIDTH)) u_blank_rise (
        .clk(SYS_CLK), .rst(SYS_RST), .enable(st_reg.enable),
        .in_level(RISE_EVENT), .count(st_reg.work.blank_rise),
        .out_level(blank_rise_q)
    );
    cog_delay_stage #(.WIDTH(COUNT_WIDTH)) u_blank_fall (
        .clk(SYS_CLK), .rst(SYS_RST), .enable(st_reg.enable),
        .in_level(FALL_EVENT), .count(st_reg.work.blank_fall),
        .out_level(blank_fall_q)
    );
    cog_delay_stage #(.WIDTH(COUNT_WIDTH)) u_phase_rise (
        .clk(SYS_CLK), .rst(SYS_RST), .enable(st_reg.enable),
        .in_level(blank_rise_q), .count(st_reg.work.phase_rise),
        .out_level(phase_rise_q)
    );
    cog_delay_stage #(.WIDTH(COUNT_WIDTH)) u_phase_fall (
        .clk(SYS_CLK), .rst(SYS_RST), .enable(st_reg.enable),
        .in_level(blank_fall_q), .count(st_reg.work.phase_fall),
        .out_level(phase_fall_q)
    );

    // Dead-band acts on the output level built from the phased events
    cog_delay_stage #(.WIDTH(COUNT_WIDTH)) u_dead_rise (
        .clk(SYS_CLK), .rst(SYS_RST), .enable(st_reg.enable),
        .in_level(out_level), .count(st_reg.work.dead_rise),
        .out_level(dead_rise_q)
    );
    cog_delay_stage #(.WIDTH(COUNT_WIDTH)) u_dead_fall (
        .clk(SYS_CLK), .rst(SYS_RST), .enable(st_reg.enable),
        .in_level(!out_level), .count(st_reg.work.dead_fall),
        .out_level(dead_fall_q)
    );

    // ------------------------------------------------------------------
    // Register file, buffer transfer and output flops
    // ------------------------------------------------------------------
    always_comb begin
        logic wr;
        logic rd;
        logic [COUNT_WIDTH-1:0] wcount;
        wr = 1'b0;
        rd = 1'b0;
        wcount = '0;
        st_next = st_reg;
        st_next.rsp.pready = 1'b0;
        st_next.rsp.pslverr = 1'b0;
        // Read data stands only in the access cycle of a read
        st_next.rsp.prdata = '0;
        wr = req.psel && !req.penable && req.pwrite;
        rd = req.psel && !req.penable && !req.pwrite;
        wcount = req.pwdata[COUNT_WIDTH-1:0];

        // Levels of the phased events set and clear the drive level, the fall event winning
        if (phase_rise_q && !phase_fall_q) begin
            st_next.drive = 1'b1;
        end else if (phase_fall_q) begin
            st_next.drive = 1'b0;
        end

        // Pending load taken on the next clock, without waiting for a generator cycle boundary
        if (st_reg.load_pending) begin
            st_next.work = st_reg.shadow;
            st_next.load_pending = 1'b0;
        end

        if (req.psel && !req.penable) begin
            st_next.rsp.pready = 1'b1;
            st_next.rsp.prdata = '0;
            case (req.paddr)
                CONTROL_ZERO_OFFSET: begin
                    if (wr) begin
                        st_next.enable = req.pwdata[ENABLE_BIT_POS];
                        // Load needs enable both before and after the write
                        if (req.pwdata[LOAD_BIT_POS] && st_reg.enable
                            && req.pwdata[ENABLE_BIT_POS]) begin
                            st_next.load_pending = 1'b1;
                        end
                    end
                    st_next.rsp.prdata[ENABLE_BIT_POS] = st_reg.enable;
                    st_next.rsp.prdata[LOAD_BIT_POS] = st_reg.load_pending;
                end
                RISING_PHASE_OFFSET: begin
                    if (wr) st_next.shadow.phase_rise = wcount;
                    st_next.rsp.prdata[COUNT_WIDTH-1:0] = st_reg.shadow.phase_rise;
                end
                FALLING_PHASE_OFFSET: begin
                    if (wr) st_next.shadow.phase_fall = wcount;
                    st_next.rsp.prdata[COUNT_WIDTH-1:0] = st_reg.shadow.phase_fall;
                end
                RISING_DEADBAND_OFFSET: begin
                    if (wr) st_next.shadow.dead_rise = wcount;
                    st_next.rsp.prdata[COUNT_WIDTH-1:0] = st_reg.shadow.dead_rise;
                end
                FALLING_DEADBAND_OFFSET: begin
                    if (wr) st_next.shadow.dead_fall = wcount;
                    st_next.rsp.prdata[COUNT_WIDTH-1:0] = st_reg.shadow.dead_fall;
                end
                RISING_BLANKING_OFFSET: begin
                    if (wr) st_next.shadow.blank_rise = wcount;
                    st_next.rsp.prdata[COUNT_WIDTH-1:0] = st_reg.shadow.blank_rise;
                end
                FALLING_BLANKING_OFFSET: begin
                    if (wr) st_next.shadow.blank_fall = wcount;
                    st_next.rsp.prdata[COUNT_WIDTH-1:0] = st_reg.shadow.blank_fall;
                end
                STATUS_OFFSET: begin
                    st_next.rsp.prdata[STATUS_OUT0_POS] = st_reg.out0;
                    st_next.rsp.prdata[STATUS_OUT1_POS] = st_reg.out1;
                    st_next.rsp.prdata[STATUS_PENDING_POS] = st_reg.load_pending;
                end
                default: begin
                    st_next.rsp.pslverr = 1'b1;
                end
            endcase
            if (!rd) begin
                st_next.rsp.prdata = '0;
            end
        end

        // Disabled: counts go straight to the working buffers
        if (!st_next.enable) begin
            st_next.work = st_next.shadow;
            st_next.load_pending = 1'b0;
        end
        // Enabled: work only changes through the load transfer above

        // Complementary flops, each side held off by its dead-band stage
        if (st_reg.enable) begin
            st_next.out0 = out_level && dead_rise_q;
            st_next.out1 = !out_level && dead_fall_q;
        end else begin
            st_next.out0 = 1'b0;
            st_next.out1 = 1'b0;
        end
    end

    assign out_level = st_reg.drive;

    // No sleep gating: runs while SYS_CLK and the events keep running
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, straight from the state flops
    // ------------------------------------------------------------------

    assign PRDATA = st_reg.rsp.prdata;
    assign PREADY = st_reg.rsp.pready;
    assign PSLVERR = st_reg.rsp.pslverr;
    assign OUT0 = st_reg.out0;
    assign OUT1 = st_reg.out1;

endmodule // cog_delay_buffer

// [design/cog_delay_stage.sv]
/*
 * One delay stage: a level change on the input appears on the output after
 * count cycles (plus the one-cycle sampling that bounds uncertainty).
 * Assumes the input is synchronous to the same clock.
 */
`timescale 1ns/10ps
module cog_delay_stage import cog_pkg::*; #(
    parameter int WIDTH = COUNT_WIDTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic in_level,
    input wire logic [WIDTH-1:0] count,
    output logic out_level
);

    typedef struct packed {
        logic out;
        logic busy;
        logic [WIDTH-1:0] remain;
    } stage_state_t;

    stage_state_t state_reg;
    stage_state_t state_next;

    // Elaboration check: counter width the logic can serve
    if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
        $error("cog_delay_stage: WIDTH out of range");
    end

    always_comb begin
        state_next = state_reg;
        if (!enable) begin
            state_next = '{out: 1'b0, busy: 1'b0, remain: '0};
        end else if (count == '0) begin
            // Zero count: event passes straight through
            state_next.out = in_level;
            state_next.busy = 1'b0;
        end else if (in_level != state_reg.out) begin
            // Registered output keeps the next stage free of added jitter
            if (!state_reg.busy) begin
                state_next.busy = 1'b1;
                state_next.remain = count - 1'b1;
            end else if (state_reg.remain == '0) begin
                state_next.out = in_level;
                state_next.busy = 1'b0;
            end else begin
                state_next.remain = state_reg.remain - 1'b1;
            end
        end else begin
            state_next.busy = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign out_level = state_reg.out;

endmodule // cog_delay_stage

// [design/cog_pkg.sv]
/*
 * Package for the complementary output generator delay and buffer block:
 * register offsets, field positions, reset values and shared types.
 * Assumes an APB slave with 32-bit data, one aligned word per register.
 */
package cog_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CONTROL_ZERO_OFFSET = 8'h00;
    localparam logic [7:0] RISING_PHASE_OFFSET = 8'h04;
    localparam logic [7:0] FALLING_PHASE_OFFSET = 8'h08;
    localparam logic [7:0] RISING_DEADBAND_OFFSET = 8'h0C;
    localparam logic [7:0] FALLING_DEADBAND_OFFSET = 8'h10;
    localparam logic [7:0] RISING_BLANKING_OFFSET = 8'h14;
    localparam logic [7:0] FALLING_BLANKING_OFFSET = 8'h18;
    localparam logic [7:0] STATUS_OFFSET = 8'h1C;

    // ------------------------------------------------------------------
    // Fields of control_register_zero and the status register
    // ------------------------------------------------------------------
    localparam int ENABLE_BIT_POS = 7;
    localparam int LOAD_BIT_POS = 6;
    localparam int STATUS_OUT0_POS = 0;
    localparam int STATUS_OUT1_POS = 1;
    localparam int STATUS_PENDING_POS = 2;

    localparam int COUNT_WIDTH = 6;
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 6'h00;

    // Count set: one entry per timing stage
    typedef struct packed {
        logic [COUNT_WIDTH-1:0] phase_rise;
        logic [COUNT_WIDTH-1:0] phase_fall;
        logic [COUNT_WIDTH-1:0] dead_rise;
        logic [COUNT_WIDTH-1:0] dead_fall;
        logic [COUNT_WIDTH-1:0] blank_rise;
        logic [COUNT_WIDTH-1:0] blank_fall;
    } count_set_t;

    localparam count_set_t COUNT_SET_RESET = '0;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage

// [verif/cog_delay_buffer_asserts.sv]
/* Checker for the delay and buffer block, watching only its top ports.
   Assumes one clock, synchronous active-high reset, bound from tb_top. */
`timescale 1ns/10ps
module cog_delay_buffer_chk import cog_pkg::*; (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic RISE_EVENT,
    input wire logic FALL_EVENT,
    input wire logic OUT0,
    input wire logic OUT1
);
    // Run length of a held fall event; saturates so it never wraps
    logic [7:0] fall_run;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !FALL_EVENT) begin
            fall_run <= 8'h00;
        end else if (fall_run != 8'hFF) begin
            fall_run <= fall_run + 8'h01;
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    AST_RDY_AFTER_SETUP: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    AST_RDY_ONE: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    AST_RDY_CAUSE: assert property (PREADY |-> $past(PSEL && !PENABLE))
        else $error("ready without setup");
    AST_ERR_WITH_RDY: assert property (PSLVERR |-> PREADY)
        else $error("error outside access cycle");
    AST_UNMAPPED: assert property (PSEL && !PENABLE && PADDR > STATUS_OFFSET |=> PSLVERR)
        else $error("unmapped address not refused");
    AST_MAPPED: assert property (PSEL && !PENABLE && PADDR <= STATUS_OFFSET
        && PADDR[1:0] == 2'h0 |=> !PSLVERR) else $error("mapped address refused");
    AST_IDLE_ZERO: assert property (!(PREADY && !PWRITE) |-> PRDATA == 32'h0)
        else $error("read data outside read access");
    AST_COUNT_WIDTH: assert property (PREADY && !PWRITE && PADDR >= RISING_PHASE_OFFSET
        && PADDR <= FALLING_BLANKING_OFFSET |-> PRDATA[31:6] == 26'h0)
        else $error("count upper bits not zero");
    AST_NOT_BOTH: assert property (!(OUT0 && OUT1))
        else $error("both outputs high");
    AST_FALL_CLEARS: assert property (fall_run >= 8'hC8 |-> !OUT0)
        else $error("primary output outlives all delays");
endmodule // cog_delay_buffer_chk

// [verif/evt_src.sv]
/* Model of the on-chip rising and falling event sources.
   Assumes the bench moves level by nonblocking write at a clock edge. */
`timescale 1ns/10ps
module evt_src (
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    output logic rise_event,
    output logic fall_event
);
    // Registered, so both events stay synchronous to the generator clock
    always_ff @(posedge clk) begin
        if (rst) begin
            rise_event <= 1'b0;
            fall_event <= 1'b0;
        end else begin
            rise_event <= level;
            fall_event <= ~level;
        end
    end
endmodule // evt_src

// [verif/tb_top.sv]
/* Self-checking bench: APB register tasks and event latency measurement.
   Assumes the package, design, checker and event model compile first. */
`timescale 1ns/10ps
module tb_top import cog_pkg::*;;
    logic SYS_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, level = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, RISE_EVENT, FALL_EVENT, OUT0, OUT1, er;
    int err_total = 0, checks = 0, n;
    always #50 SYS_CLK = ~SYS_CLK;
    cog_delay_buffer uut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RISE_EVENT(RISE_EVENT),
        .FALL_EVENT(FALL_EVENT), .OUT0(OUT0), .OUT1(OUT1));
    evt_src src (.clk(SYS_CLK), .rst(SYS_RST), .level(level), .rise_event(RISE_EVENT),
        .fall_event(FALL_EVENT));
    // ------------------------------------------------------------------
    // Compare, bus and measurement tasks
    // ------------------------------------------------------------------
    task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int got);
        checks++;
        if (got < lo || got > lo + 1) begin
            err_total++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, lo + 1, got);
        end
    endtask
    // Trailing idle edge keeps two calls from driving PSEL in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk32(nm, exp, rd);
    endtask
    // Edges from the one that samples the rise event until OUT0 is seen
    task automatic meas(input int lo);
        level <= 1'b0;
        do @(posedge SYS_CLK); while (OUT1 !== 1'b1);
        level <= 1'b1;
        do @(posedge SYS_CLK); while (RISE_EVENT !== 1'b1);
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (OUT0 !== 1'b1);
        chk_rng("rise latency", lo, n);
    endtask
    task automatic print_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        @(posedge SYS_CLK);
        for (int i = 0; i < 8; i++) rchk("reset value", 8'(4 * i), 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk32("unmapped error", 32'h1, {31'h0, er});
        for (int i = 1; i < 7; i++) begin
            apb(1'b1, 8'(4 * i), 32'hFFFFFFC0 | i);
            rchk("count readback", 8'(4 * i), 32'(i));
            apb(1'b1, 8'(4 * i), 32'h0);
        end
        apb(1'b1, CONTROL_ZERO_OFFSET, 32'h80);
        meas(5);
        apb(1'b1, CONTROL_ZERO_OFFSET, 32'h0);
        rchk("disabled status", STATUS_OFFSET, 32'h0);
        apb(1'b1, RISING_PHASE_OFFSET, 32'h3);
        apb(1'b1, RISING_DEADBAND_OFFSET, 32'h2);
        apb(1'b1, CONTROL_ZERO_OFFSET, 32'h80);
        meas(10);
        apb(1'b1, RISING_PHASE_OFFSET, 32'h0);
        apb(1'b1, RISING_DEADBAND_OFFSET, 32'h0);
        meas(10);
        apb(1'b1, CONTROL_ZERO_OFFSET, 32'h80);
        meas(10);
        apb(1'b1, CONTROL_ZERO_OFFSET, 32'hC0);
        rchk("load self clear", CONTROL_ZERO_OFFSET, 32'h80);
        meas(5);
        rchk("status", STATUS_OFFSET, 32'h1);
        level <= 1'b0;
        // Long fall hold lets the checker see every delay drain
        repeat (210) @(posedge SYS_CLK);
        print_verdict();
    end
    initial begin
        #3000000;
        err_total++;
        print_verdict();
    end
endmodule // tb_top
bind cog_delay_buffer cog_delay_buffer_chk chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RISE_EVENT(RISE_EVENT),
    .FALL_EVENT(FALL_EVENT), .OUT0(OUT0), .OUT1(OUT1));
